// *** verilog/mbc_pkg.sv ***
// Purpose: Shared constants and carriers for the monitor board configuration logic
// Assumes: 200 MHz mclk; all bus and switch inputs are asynchronous pins
// Notes:   Switch positions are packed with the leftmost position in the msb
package mbc_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_HZ        = 200_000_000;
    localparam int CLK_PERIOD_PS = 5000;
    localparam int WAIT_STATE_NS = 250;   // One bus period at the faster processor clock
    localparam int WAIT_CYC      = (WAIT_STATE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // ****************************************************************
    // Address map
    // ****************************************************************
    localparam logic [7:0]  CFG_PORT_A    = 8'h7a;   // Start-up switch port
    localparam logic [7:0]  CFG_PORT_B    = 8'h7b;   // Mirror of the same switch
    localparam logic [15:0] ROM_MON_BASE  = 16'hf000;
    localparam logic [15:0] ROM_MON_LAST  = 16'hf7ff;
    localparam logic [15:0] ROM_EXT_BASE  = 16'hf800;
    localparam logic [15:0] ROM_EXT_LAST  = 16'hfbff;
    localparam logic [15:0] RAM_BASE      = 16'hfc00;
    localparam logic [15:0] RAM_LAST      = 16'hffff;
    localparam int          RAM_WORDS     = 1024;
    localparam int          RAM_SEG_BIT   = 9;       // Address bit that splits the two segments

    // ****************************************************************
    // Reset jump
    // ****************************************************************
    localparam logic [7:0] JUMP_OPCODE   = 8'hc3;    // Absolute jump
    localparam logic [7:0] JUMP_LOW_BYTE = 8'h00;    // Page boundary
    localparam logic [7:0] JUMP_OFF      = 8'h00;    // All positions off
    localparam logic [7:0] JUMP_DEFAULT  = 8'hf0;    // Factory page

    // ****************************************************************
    // Cassette option switch field positions
    // ****************************************************************
    localparam int OPT_LEVEL    = 7;
    localparam int OPT_RATE     = 6;
    localparam int OPT_RX_INV   = 5;
    localparam int OPT_TX_INV   = 4;
    localparam int OPT_LO_GUARD = 3;
    localparam int OPT_HI_GUARD = 2;
    localparam int OPT_B2400    = 1;
    localparam int OPT_B1200    = 0;

    // ****************************************************************
    // Bit rate indices, in the order the jumper pins are laid out
    // ****************************************************************
    localparam logic [2:0] RATE_9600 = 3'h0;
    localparam logic [2:0] RATE_2400 = 3'h2;
    localparam logic [2:0] RATE_1200 = 3'h3;
    localparam logic [2:0] RATE_110  = 3'h6;
    localparam logic [2:0] RATE_NONE = 3'h7;   // No jumper fitted
    localparam logic [2:0] TTY_DEFAULT_RATE = RATE_110;
    localparam logic [2:0] VID_DEFAULT_RATE = RATE_9600;

    // Divisor from mclk to one bit time for a rate index
    function automatic logic [23:0] mbc_divisor(input int clk_hz, input logic [2:0] idx);
        int baud;
        baud = 110;
        case (idx)
            3'h0:    baud = 9600;
            3'h1:    baud = 4800;
            3'h2:    baud = 2400;
            3'h3:    baud = 1200;
            3'h4:    baud = 600;
            3'h5:    baud = 300;
            default: baud = 110;
        endcase
        return 24'(clk_hz / baud);
    endfunction

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  dout;
        logic        psync;
        logic        pdbin;
        logic        pwr_n;
        logic        sout;
        logic        sinp;
        logic        smemr;
    } mbc_bus_t;

    typedef struct packed {
        logic [7:0] startup;
        logic [7:0] jump;
        logic [7:0] option;
        logic [2:0] tty_rate;
        logic [2:0] vid_rate;
        logic       ready_req;
        logic       cas_rx;
    } mbc_sw_t;

    typedef enum logic [4:0] {
        ST_CAPTURE = 5'b00001,
        ST_OP      = 5'b00010,
        ST_LO      = 5'b00100,
        ST_HI      = 5'b01000,
        ST_NORMAL  = 5'b10000
    } mbc_state_t;

endpackage

// *** verilog/mbc_baud_gen.sv ***
// Purpose: Bit-time tick generator for one serial channel
// Assumes: rate_sel is already synchronous to mclk
// Notes:   A change of rate restarts the count so no short bit is produced
`timescale 1ns/1ps
module mbc_baud_gen
    import mbc_pkg::*;
#(
    parameter int CLK_HZ_P = CLK_HZ
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire logic [2:0] rate_sel,
    output logic            tick
);

    logic [23:0] count;
    logic [2:0]  rate_d;

    // ****************************************************************
    // Divider
    // ****************************************************************
    always_ff @(posedge mclk) begin
        rate_d <= rate_sel;
        if (reset || rate_sel != rate_d) begin
            count <= 24'h000000;
            tick  <= 1'b0;
        end else if (count >= mbc_divisor(CLK_HZ_P, rate_sel) - 24'h000001) begin
            count <= 24'h000000;
            tick  <= 1'b1;
        end else begin
            count <= count + 24'h000001;
            tick  <= 1'b0;
        end
    end

endmodule

// *** verilog/mbc_config.sv ***
// Purpose: Switch ports, reset jump, address decode and bus glue of the monitor card
// Assumes: All bus and switch inputs are asynchronous; reset held at least 3 mclk edges
// Notes:   Every bus and switch pin passes two flops, so the card answers three mclk edges late
// Operation
// - After reset, first execution goes to a 256-byte page set by jump switch.
// - Jump switch is the target high byte, leftmost position msb; default F000.
// - Jump switch all off means no jump; reset behaves normally.
// - I/O read of either assigned port returns the start-up switch byte.
// - Input polarity switch on inverts cassette receive data.
// - Output polarity switch on inverts cassette send data, independently.
// - Each guard switch protects one RAM segment; top writable, bottom protected.
// - Cassette runs at 2400 or 1200 baud by its rate switches; default 1200.
// - Teletype and video ports each take one of seven rates by jumper.
// - Default rates are 110 baud teletype and 9600 baud video.
// - Decode F000-F7FF monitor ROM, F800-FBFF extension ROM, FC00-FFFF RAM.
// - The card can drive the memory-write strobe itself.
// - Wait-state logic stretches cycles for the faster processor.
// - Memory-write strobe is processor write AND not status-output.
// - With ready-request option on, exactly one wait state per bus cycle.
// - Memory-read strobe is clamped during the jump sequence.
`timescale 1ns/1ps
module mbc_config
    import mbc_pkg::*;
#(
    parameter int CLK_HZ_P = CLK_HZ
) (
    input  wire logic       mclk,
    input  wire logic       reset,
    input  wire mbc_bus_t   bus_in,
    input  wire mbc_sw_t    sw_in,
    input  wire logic       cas_tx_data,
    output logic [7:0]      bus_di,
    output logic            bus_di_drive,
    output logic            mwrite,
    output logic            prdy,
    output logic            smemr_clamp,
    output logic            rom_mon_sel,
    output logic            rom_ext_sel,
    output logic            cas_rx_data,
    output logic            cas_tx_pin,
    output logic            cas_level_high,
    output logic            tty_tick,
    output logic            vid_tick,
    output logic            cas_tick
);

    mbc_bus_t   bus_m;
    mbc_bus_t   bs;
    mbc_sw_t    sw_m;
    mbc_sw_t    sw;
    logic       pdbin_d;
    logic       wr_d;
    logic       psync_d;
    mbc_state_t state;
    mbc_state_t next_state;
    logic [7:0] page;
    logic [7:0] ram [RAM_WORDS];
    logic [7:0] wait_cnt;
    logic [2:0] rate_sel [3];
    logic [2:0] tick_raw;
    logic       rd_edge;
    logic       wr_now;
    logic       wr_edge;
    logic       ram_hit;
    logic       mon_hit;
    logic       ext_hit;
    logic       cfg_hit;
    logic       jamming;
    logic       writable;
    logic       ram_we;
    logic [9:0] ram_idx;
    // Every assertion below runs on mclk and rests while reset is held
    default clocking @(posedge mclk);
    endclocking
    default disable iff (reset);

    // ****************************************************************
    // Input synchronisers
    // ****************************************************************
    // Two stages on every bus and switch pin; the strobe history reads the second stage only and
    // tracks it through reset, so a strobe already high at release is no edge
    always_ff @(posedge mclk) begin
        bus_m   <= bus_in;
        bs      <= bus_m;
        sw_m    <= sw_in;
        sw      <= sw_m;
        pdbin_d <= bs.pdbin;
        wr_d    <= wr_now;
        psync_d <= bs.psync;
    end

    // ****************************************************************
    // Decode
    // ****************************************************************
    assign rd_edge  = bs.pdbin && !pdbin_d;
    assign wr_now   = !bs.pwr_n && !bs.sout;
    assign wr_edge  = wr_now && !wr_d;
    assign ram_hit  = bs.addr >= RAM_BASE && bs.addr <= RAM_LAST;
    assign mon_hit  = bs.addr >= ROM_MON_BASE && bs.addr <= ROM_MON_LAST;
    assign ext_hit  = bs.addr >= ROM_EXT_BASE && bs.addr <= ROM_EXT_LAST;
    assign cfg_hit  = bs.addr[7:0] == CFG_PORT_A || bs.addr[7:0] == CFG_PORT_B;
    assign jamming  = state == ST_OP || state == ST_LO || state == ST_HI;
    assign ram_idx  = bs.addr[9:0];
    // Top position of a guard switch reads as one and means writable
    assign writable = ram_idx[RAM_SEG_BIT] ? sw.option[OPT_HI_GUARD]
                                           : sw.option[OPT_LO_GUARD];
    assign ram_we   = wr_edge && ram_hit && writable && !jamming;

    // ****************************************************************
    // Reset jump sequencer
    // ****************************************************************
    // The switch is caught one edge after release, never inside the reset branch
    always_comb begin
        next_state = state;
        case (state)
            ST_CAPTURE: next_state = (sw.jump == JUMP_OFF) ? ST_NORMAL : ST_OP;
            ST_OP:      if (rd_edge && bs.smemr) next_state = ST_LO;
            ST_LO:      if (rd_edge && bs.smemr) next_state = ST_HI;
            ST_HI:      if (rd_edge && bs.smemr) next_state = ST_NORMAL;
            ST_NORMAL:  next_state = ST_NORMAL;
            default:    next_state = ST_CAPTURE;
        endcase
    end

    // Page and clamp move with the state; the clamp keeps other memory boards
    // off the bus while jam bytes are served
    always_ff @(posedge mclk) begin
        if (reset) begin
            state       <= ST_CAPTURE;
            page        <= JUMP_DEFAULT;
            smemr_clamp <= 1'b0;
        end else begin
            state       <= next_state;
            smemr_clamp <= next_state == ST_OP || next_state == ST_LO
                        || next_state == ST_HI;
            if (state == ST_CAPTURE) begin
                page <= sw.jump;
            end
        end
    end

    // ****************************************************************
    // Read data path
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            bus_di       <= 8'h00;
            bus_di_drive <= 1'b0;
        end else if (rd_edge) begin
            bus_di_drive <= (bs.smemr && (jamming || ram_hit)) || (bs.sinp && cfg_hit);
            if (bs.smemr && jamming) begin
                bus_di <= (state == ST_OP) ? JUMP_OPCODE
                        : (state == ST_LO) ? JUMP_LOW_BYTE : page;
            end else if (bs.smemr && ram_hit) begin
                bus_di <= ram[ram_idx];
            end else if (bs.sinp && cfg_hit) begin
                bus_di <= sw.startup;
            end
        end else if (!bs.pdbin) begin
            bus_di_drive <= 1'b0;
        end
    end

    // RAM; a protected segment simply drops the write
    always_ff @(posedge mclk) begin
        if (ram_we) begin
            ram[ram_idx] <= bs.dout;
        end
    end

    // ROM chip selects, held off while the jump owns the bus
    always_ff @(posedge mclk) begin
        if (reset) begin
            rom_mon_sel <= 1'b0;
            rom_ext_sel <= 1'b0;
        end else begin
            rom_mon_sel <= bs.smemr && mon_hit && !jamming;
            rom_ext_sel <= bs.smemr && ext_hit && !jamming;
        end
    end

    // ****************************************************************
    // Bus glue: write strobe and wait state
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            mwrite <= 1'b0;
        end else begin
            mwrite <= wr_now;
        end
    end

    // One processor clock of wait, counted in mclk cycles
    always_ff @(posedge mclk) begin
        if (reset) begin
            prdy     <= 1'b1;
            wait_cnt <= 8'h00;
        end else if (bs.psync && !psync_d && sw.ready_req) begin
            prdy     <= 1'b0;
            wait_cnt <= 8'(WAIT_CYC - 1);
        end else if (wait_cnt != 8'h00) begin
            wait_cnt <= wait_cnt - 8'h01;
        end else begin
            prdy     <= 1'b1;
        end
    end

    // ****************************************************************
    // Cassette options
    // ****************************************************************
    always_ff @(posedge mclk) begin
        if (reset) begin
            cas_rx_data    <= 1'b0;
            cas_tx_pin     <= 1'b0;
            cas_level_high <= 1'b0;
        end else begin
            cas_rx_data    <= sw.cas_rx ^ sw.option[OPT_RX_INV];
            cas_tx_pin     <= cas_tx_data ^ sw.option[OPT_TX_INV];
            cas_level_high <= sw.option[OPT_LEVEL];
        end
    end

    // ****************************************************************
    // Bit rate selection
    // ****************************************************************
    // Both cassette switches on is a user fault; the lower rate is kept then
    assign rate_sel[2] = (sw.option[OPT_B2400] && !sw.option[OPT_B1200])
                       ? RATE_2400 : RATE_1200;
    assign rate_sel[0] = (sw.tty_rate == RATE_NONE) ? TTY_DEFAULT_RATE : sw.tty_rate;
    assign rate_sel[1] = (sw.vid_rate == RATE_NONE) ? VID_DEFAULT_RATE : sw.vid_rate;

    // One divider per channel: teletype, video, cassette
    for (genvar ch = 0; ch < 3; ch++) begin : g_baud
        mbc_baud_gen #(.CLK_HZ_P(CLK_HZ_P)) u_baud (
            .mclk     (mclk),
            .reset    (reset),
            .rate_sel (rate_sel[ch]),
            .tick     (tick_raw[ch])
        );
    end

    // Retimed so the top outputs leave from flip-flops of this module
    always_ff @(posedge mclk) begin
        if (reset) begin
            {cas_tick, vid_tick, tty_tick} <= 3'h0;
        end else begin
            {cas_tick, vid_tick, tty_tick} <= tick_raw;
        end
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_jump_arm;
        (state == ST_CAPTURE && sw.jump != JUMP_OFF) |=> state == ST_OP ##0 smemr_clamp;
    endproperty
    a_jump_arm: assert property (p_jump_arm) else $error("jump not armed");
    property p_jam_page;
        (rd_edge && bs.smemr && state == ST_HI) |=> bus_di == page && bus_di_drive;
    endproperty
    a_jam_page: assert property (p_jam_page) else $error("wrong jump page");
    property p_no_jump;
        (state == ST_CAPTURE && sw.jump == JUMP_OFF) |=> state == ST_NORMAL && !smemr_clamp;
    endproperty
    a_no_jump: assert property (p_no_jump) else $error("jump with switch off");
    property p_cfg_read;
        (rd_edge && bs.sinp && !bs.smemr && cfg_hit) |=> bus_di == $past(sw.startup);
    endproperty
    a_cfg_read: assert property (p_cfg_read) else $error("switch port wrong");
    property p_rx_inv;
        !$past(reset) |-> cas_rx_data == ($past(sw.cas_rx) ^ $past(sw.option[OPT_RX_INV]));
    endproperty
    a_rx_inv: assert property (p_rx_inv) else $error("rx polarity wrong");
    // The stored byte itself must survive, not just the enable term
    property p_guard;
        (wr_edge && ram_hit && !writable) |=> ram[$past(ram_idx)] == $past(ram[ram_idx]);
    endproperty
    a_guard: assert property (p_guard) else $error("protected write taken");
    property p_mwrite;
        mwrite |-> $past(!bs.pwr_n) && $past(!bs.sout);
    endproperty
    a_mwrite: assert property (p_mwrite) else $error("mwrite without cause");
    property p_wait;
        (bs.psync && !psync_d && sw.ready_req && wait_cnt == 8'h00)
            |=> (!prdy)[*8] ##[1:60] prdy;
    endproperty
    a_wait: assert property (p_wait) else $error("wait state length wrong");
    property p_once;
        state == ST_NORMAL |=> state == ST_NORMAL && !smemr_clamp;
    endproperty
    a_once: assert property (p_once) else $error("jump re-entered");

endmodule

// *** sim/mbc_host.sv ***
// Purpose: Host processor model running memory and port cycles on the card
// Assumes: Card passes every strobe through two flops
// Notes:   Released address and data lines show the inverse of the last value
`timescale 1ns/1ps
module mbc_host
    import mbc_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic [11:0] resp,
    output mbc_bus_t         bus
);
    // ****************************************************************
    // Bus cycles
    // ****************************************************************
    // Idle bus: no strobe active, write strobe high
    initial begin
        bus = '0;
        bus.pwr_n = 1'b1;
    end

    // Address settles 3 cycles before the strobe; reply taken 4 cycles into it
    task automatic cyc(input logic wr, input logic io, input logic [15:0] a,
                       input logic [7:0] d, output logic [11:0] s);
        @(negedge mclk);
        bus.addr = a;
        bus.dout = d;
        bus.sinp = io & ~wr;
        bus.sout = io & wr;       // Memory writes keep status-output low
        bus.smemr = ~io & ~wr;
        repeat (3) @(negedge mclk);
        bus.pdbin = ~wr;
        bus.pwr_n = ~wr;
        repeat (4) @(negedge mclk);
        s = resp;
        bus.pdbin = 1'b0;
        bus.pwr_n = 1'b1;
        repeat (4) @(negedge mclk);
        bus.addr = ~a;            // Stale lines never show the old value
        bus.dout = ~d;
        bus.sinp = 1'b0;
        bus.smemr = 1'b0;
    endtask

    // One machine-cycle start marker
    task automatic sync_pulse;
        @(negedge mclk);
        bus.psync = 1'b1;
        @(negedge mclk);
        bus.psync = 1'b0;
    endtask
endmodule

// *** sim/tb.sv ***
// Purpose: Self-checking bench for the monitor card configuration logic
// Assumes: Baud clock parameter shrunk so bit times stay short
// Notes:   Reply word is drive, monitor select, extension select, mwrite, data
`timescale 1ns/1ps
module tb
    import mbc_pkg::*;
;
    localparam int CLKH = 600000;
    logic       mclk = 1'b0;
    logic       reset = 1'b1;
    logic       cas_tx_data;
    logic [7:0] bus_di;
    logic       drv, mwrite, prdy, clamp, mon, ext, rxd, txp, ttk, vtk, ctk, lvl;
    logic [11:0] s, m;
    mbc_sw_t    sw;
    mbc_bus_t   bus;
    int         error_cnt = 0;
    int         total_checks = 0;
    int         n, k;
    typedef struct packed {logic wr; logic io; logic [15:0] a; logic [7:0] d;
                           logic [3:0] f;} mbc_row_t;
    mbc_row_t   rows [11] = '{'{0, 1, 16'h007a, 8'h41, 4'h8}, '{0, 1, 16'h007b, 8'h41, 4'h8},
        '{1, 0, 16'hfc10, 8'ha5, 4'h1}, '{1, 0, 16'hfe10, 8'h3c, 4'h1},
        '{0, 0, 16'hfc10, 8'ha5, 4'h8}, '{0, 0, 16'hfe10, 8'h3c, 4'h8},
        '{0, 0, 16'hf000, 8'h00, 4'h4}, '{0, 0, 16'hf7ff, 8'h00, 4'h4},
        '{0, 0, 16'hf800, 8'h00, 4'h2}, '{0, 0, 16'hfbff, 8'h00, 4'h2},
        '{0, 1, 16'h007c, 8'h00, 4'h0}};
    int         bauds [7] = '{9600, 4800, 2400, 1200, 600, 300, 110};

    always #2.5 mclk = ~mclk;

    mbc_config #(.CLK_HZ_P(CLKH)) mbc_config_i (.mclk(mclk), .reset(reset), .bus_in(bus),
        .sw_in(sw), .cas_tx_data(cas_tx_data), .bus_di(bus_di), .bus_di_drive(drv),
        .mwrite(mwrite), .prdy(prdy), .smemr_clamp(clamp), .rom_mon_sel(mon),
        .rom_ext_sel(ext), .cas_rx_data(rxd), .cas_tx_pin(txp), .cas_level_high(lvl),
        .tty_tick(ttk), .vid_tick(vtk), .cas_tick(ctk));
    mbc_host mbc_host_i (.mclk(mclk), .resp({drv, mon, ext, mwrite, bus_di}), .bus(bus));

    // ****************************************************************
    // Helpers
    // ****************************************************************
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Cycles between two ticks of one channel, sampled away from the edge
    task automatic period(input int w, output int p);
        for (k = 0; k < 30000 && (w == 0 ? vtk : w == 1 ? ctk : ttk) !== 1'b1; k++)
            @(negedge mclk);
        p = 0;
        do begin
            @(negedge mclk);
            p++;
        end while ((w == 0 ? vtk : w == 1 ? ctk : ttk) !== 1'b1 && p < 30000);
    endtask

    task automatic test_done;
        if (error_cnt == 0 && total_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Hang guard well beyond the longest expected run
    initial begin
        #(80000 * 5);
        error_cnt++;
        test_done();
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        sw = '0;
        sw.startup = 8'h41;
        sw.jump = JUMP_DEFAULT;
        sw.option = 8'h2d;      // One cassette rate switch only, both guards open
        sw.tty_rate = 3'h7;
        sw.vid_rate = 3'h7;
        sw.cas_rx = 1'b1;
        cas_tx_data = 1'b1;
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        repeat (3) @(negedge mclk);
        chk(12'(clamp), 12'h001);
        mbc_host_i.cyc(0, 0, 16'h0000, 8'h00, s);
        chk(s, 12'h8c3);
        mbc_host_i.cyc(0, 0, 16'h0000, 8'h00, s);
        chk(s, 12'h800);
        mbc_host_i.cyc(0, 0, 16'h0000, 8'h00, s);
        chk(s, 12'h8f0);
        chk(12'(clamp), 12'h000);
        foreach (rows[i]) begin
            mbc_host_i.cyc(rows[i].wr, rows[i].io, rows[i].a, rows[i].d, s);
            m = rows[i].f[3] ? 12'hfff : 12'hf00;   // Writes and selects carry no data
            chk(s & m, {rows[i].f, rows[i].d} & m);
        end
        // Upper segment guarded: a write there must leave the old byte
        sw.option = 8'ha9;      // Level high as well
        repeat (4) @(negedge mclk);
        mbc_host_i.cyc(1, 0, 16'hfe10, 8'h5a, s);
        mbc_host_i.cyc(0, 0, 16'hfe10, 8'h00, s);
        chk(s, 12'h83c);
        chk(12'({lvl, rxd, txp}), 12'h005);
        period(1, n);
        chk(12'(n), 12'(CLKH / 1200));
        period(2, n);
        chk(12'(n), 12'(CLKH / 110));
        period(0, n);
        chk(12'(n), 12'(CLKH / 9600));
        sw.option = 8'h1a;
        repeat (4) @(negedge mclk);
        chk(12'({lvl, rxd, txp}), 12'h002);
        period(1, n);
        chk(12'(n), 12'(CLKH / 2400));
        for (int r = 0; r < 7; r++) begin
            sw.vid_rate = 3'(r);
            period(0, n);
            period(0, n);
            chk(12'(n), 12'(CLKH / bauds[r]));
        end
        // One wait state per cycle start when the option is fitted
        sw.ready_req = 1'b1;
        repeat (4) @(negedge mclk);
        mbc_host_i.sync_pulse();
        for (k = 0; k < 10 && prdy !== 1'b0; k++)
            @(negedge mclk);
        n = 0;
        while (prdy !== 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        chk(12'(n), 12'(WAIT_CYC));
        // Jump switch all off: the first read is a plain port read
        reset = 1'b1;
        sw.jump = JUMP_OFF;
        repeat (20) @(negedge mclk);
        reset = 1'b0;
        repeat (3) @(negedge mclk);
        chk(12'(clamp), 12'h000);
        mbc_host_i.cyc(0, 1, 16'h007a, 8'h00, s);
        chk(s, 12'h841);
        mbc_host_i.cyc(0, 0, 16'hfc10, 8'h00, s);
        chk(s, 12'h8a5);
        test_done();
    end
endmodule
